// ==== aea_host_model.sv ====
/*
 * Host model for the active energy accumulator: a plain register master
 * with write, read and threshold-programming tasks called by the bench.
 * Assumes single-cycle strobes and read data in the cycle after a read.
 */
`timescale 1ns/100ps

module aea_host_model (
   input  wire logic                  clk,
   output aea_pkg::aea_bus_req_t      bus_req,
   input  wire logic [31:0]           rdata
);
   import aea_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Idle bus starts at zero; after each access it shows an inverted pattern so stale values are never trusted
   initial begin
      bus_req = '0;
   end

   // One-cycle write strobe, released with scrambled address and data
   task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask : write_reg

   // Read data is taken at the edge after the one that samples the strobe
   task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus_req <= '{addr: ~a, wdata: 32'hffffffff, wr: 1'b0, rd: 1'b0};
      @(posedge clk);
      d = rdata;
   endtask : read_reg

   // Threshold kept non-negative and inside 47 magnitude bits
   task automatic write_thr(input logic [47:0] thr);
      logic [47:0] t;
      t = thr & 48'h7fffffffffff;
      write_reg(ADDR_THR_HIGH, {8'h0, t[47:24]});
      write_reg(ADDR_THR_LOW, {8'h0, t[23:0]});
   endtask : write_thr

endmodule : aea_host_model

// ==== aea_pkg.sv ====
/*
 * Package for the active energy accumulator: register map, field positions,
 * reset values, sample timing and the structs carried between blocks.
 * Assumes a 10 MHz system clock and a plain single-cycle register port.
 */
package aea_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timing: the first stage runs once per 125 us sample period
   localparam int CLK_PERIOD_NS    = 100;
   localparam int SAMPLE_PERIOD_NS = 125000;
   localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int DIV_W            = $clog2(SAMPLE_CYCLES);

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] ADDR_THR_LOW    = 8'h00;
   localparam logic [7:0] ADDR_THR_HIGH   = 8'h04;
   localparam logic [7:0] ADDR_ENERGY0    = 8'h08;  // Total A, B, C then fund A, B, C
   localparam logic [7:0] ADDR_ENERGY5    = 8'h1c;
   localparam logic [7:0] ADDR_STATUS     = 8'h20;
   localparam logic [7:0] ADDR_MASK       = 8'h24;
   localparam logic [7:0] ADDR_PHASE_SIGN = 8'h28;
   localparam logic [7:0] ADDR_ACC_CFG    = 8'h2c;
   localparam logic [7:0] ADDR_LINE_CFG   = 8'h30;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions and widths
   localparam int THR_W          = 48;
   localparam int THR_HALF_W     = 24;
   localparam int ACC_W          = 50;
   localparam int PWR_W          = 32;
   localparam int SMP_W          = 16;
   localparam int STAT_W         = 9;
   localparam int STAT_TOT_HF    = 0;
   localparam int STAT_FUND_HF   = 1;
   localparam int STAT_REV_LSB   = 6;
   localparam int CFG_SEL_BIT    = 6;
   localparam int CFG_WIRING_CONFIG_SEL_LSB = 4;
   localparam int LCC_CLR_BIT    = 6;
   localparam int HF_BIT         = 30;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [THR_W-1:0]  THR_RESET    = 48'h0;
   localparam logic [STAT_W-1:0] MASK_RESET   = 9'h000;
   localparam logic [1:0]        WIRING_CONFIG_SEL_RESET = 2'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Wiring configuration codes for phase B
   localparam logic [1:0] WIRE_NORMAL   = 2'h0;
   localparam logic [1:0] WIRE_B_ZERO   = 2'h1;
   localparam logic [1:0] WIRE_B_NEG_AC = 2'h2;
   localparam logic [1:0] WIRE_B_NEG_A  = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } aea_bus_req_t;

   typedef struct packed {
      logic signed [PWR_W-1:0] a;
      logic signed [PWR_W-1:0] c;
   } aea_ac_pwr_t;

   typedef struct packed {
      logic signed [SMP_W-1:0] va;
      logic signed [SMP_W-1:0] vb;
      logic signed [SMP_W-1:0] vc;
      logic signed [SMP_W-1:0] ib;
   } aea_volt_t;

   typedef struct packed {
      logic [ACC_W-1:0] acc;
      logic             up;
      logic             dn;
   } aea_step_t;

endpackage : aea_pkg

// ==== aea_top.sv ====
/*
 * Active energy accumulator for three phases, total and fundamental power.
 * First stage integrates power per 8 kHz sample against a shared threshold;
 * second stage counts the resulting pulses into 32-bit signed energy counts.
 * Assumes power and voltage samples come from logic on the same clock and
 * hold steady across the sample strobe; registers are reached over a plain
 * address / strobe port with read data one cycle after the read strobe.
 */
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/100ps

module aea_top (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire aea_pkg::aea_bus_req_t bus_req,
   output logic [31:0]               rdata,
   input  wire aea_pkg::aea_ac_pwr_t tot_pwr_ac,
   input  wire aea_pkg::aea_ac_pwr_t fund_pwr_ac,
   input  wire aea_pkg::aea_volt_t   tot_volt,
   input  wire aea_pkg::aea_volt_t   fund_volt,
   output logic                      interrupt_out_n,
   output logic [5:0]                energy_pulse
);
   import aea_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Whole module state
   typedef struct packed {
      logic [DIV_W-1:0]            div;
      logic [5:0][ACC_W-1:0]       acc;
      logic [5:0][31:0]            cnt;
      logic [5:0]                  last_sign;
      logic [2:0]                  psign;
      logic [STAT_W-1:0]           status;
      logic [STAT_W-1:0]           mask;
      logic [THR_W-1:0]            thr;
      logic [THR_HALF_W-1:0]       thr_lo;
      logic [THR_HALF_W-1:0]       thr_hi;
      logic                        lo_wr;
      logic                        hi_wr;
      logic                        sel;
      logic [1:0]                  wiring_config_sel;
      logic                        clr_rd;
      logic [31:0]                 rdata;
      logic                        irq_n;
      logic [5:0]                  pulse;
   } aea_state_t;

   aea_state_t q;
   aea_state_t d;

   ////////////////////////////////////////////////////////////////////////////
   // One sample step: signed add, then at most one pulse per sample either way
   function automatic aea_step_t acc_step(input logic [ACC_W-1:0] acc,
                                          input logic [PWR_W-1:0] pwr,
                                          input logic [THR_W-1:0] thr);
      logic signed [ACC_W-1:0] sum;
      logic signed [ACC_W-1:0] t;
      aea_step_t               r;
      sum = $signed(acc) + ACC_W'($signed(pwr));
      t   = ACC_W'($signed(thr));
      r.acc = sum;
      r.up  = 1'b0;
      r.dn  = 1'b0;
      if (sum >= t) begin
         r.acc = sum - t;
         r.up  = 1'b1;
      end else if (sum <= -t) begin
         r.acc = sum + t;
         r.dn  = 1'b1;
      end
      return r;
   endfunction : acc_step

   // Phase B power from the selected wiring
   function automatic logic [PWR_W-1:0] b_power(input aea_volt_t v,
                                                input logic [1:0] code);
      logic signed [SMP_W+1:0]  vsel;
      logic signed [2*SMP_W+1:0] prod;
      case (code)
         WIRE_NORMAL:   vsel = (SMP_W+2)'(v.vb);
         WIRE_B_ZERO:   vsel = '0;
         WIRE_B_NEG_AC: vsel = -(SMP_W+2)'(v.va) - (SMP_W+2)'(v.vc);
         WIRE_B_NEG_A:  vsel = -(SMP_W+2)'(v.va);
         default:       vsel = '0;
      endcase
      prod = vsel * (2*SMP_W+2)'(v.ib);
      return PWR_W'(prod);
   endfunction : b_power

   ////////////////////////////////////////////////////////////////////////////
   // Combinational helpers
   logic                    sample_en;
   logic [5:0][PWR_W-1:0]   pwr;
   aea_step_t [5:0]         step;
   logic [5:0]              rev_set;
   logic                    e_hit;
   logic [2:0]              e_idx;

   assign sample_en = (q.div == DIV_W'(SAMPLE_CYCLES - 1));
   assign e_hit     = (bus_req.addr >= ADDR_ENERGY0) && (bus_req.addr <= ADDR_ENERGY5)
                      && (bus_req.addr[1:0] == 2'h0);
   assign e_idx     = 3'((bus_req.addr - ADDR_ENERGY0) >> 2);

   // Chain inputs: total A, B, C then fundamental A, B, C
   always_comb begin
      pwr[0] = tot_pwr_ac.a;
      pwr[1] = b_power(tot_volt, q.wiring_config_sel);
      pwr[2] = tot_pwr_ac.c;
      pwr[3] = fund_pwr_ac.a;
      pwr[4] = b_power(fund_volt, q.wiring_config_sel);
      pwr[5] = fund_pwr_ac.c;
      for (int k = 0; k < 6; k++) begin
         step[k] = acc_step(q.acc[k], pwr[k], q.thr);
      end
   end

   // Reversal events from the monitored power type only
   always_comb begin
      int k;
      k = 0;
      for (int p = 0; p < 3; p++) begin
         k = q.sel ? p + 3 : p;
         rev_set[p]     = sample_en && (step[k].up || step[k].dn)
                          && (step[k].dn != q.last_sign[k]);
         rev_set[p + 3] = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      logic [STAT_W-1:0] set;
      logic [STAT_W-1:0] clr;
      logic [31:0]       nc;
      d   = q;
      set = '0;
      clr = '0;
      nc  = '0;
      d.pulse = '0;
      d.div   = sample_en ? '0 : q.div + 1'b1;

      // First and second stage, one chain per phase and power type
      for (int k = 0; k < 6; k++) begin
         nc = q.cnt[k];
         if (sample_en) begin
            d.acc[k]   = step[k].acc;
            d.pulse[k] = step[k].up || step[k].dn;
            if (step[k].up || step[k].dn) begin
               d.last_sign[k] = step[k].dn;
            end
            if (step[k].up) begin
               nc = q.cnt[k] + 32'h1;
            end else if (step[k].dn) begin
               nc = q.cnt[k] - 32'h1;
            end
         end
         if (nc[HF_BIT] != q.cnt[k][HF_BIT]) begin
            set[k < 3 ? STAT_TOT_HF : STAT_FUND_HF] = 1'b1;
         end
         // A pulse landing in the clearing read's cycle is kept
         if (bus_req.rd && e_hit && (e_idx == 3'(k)) && q.clr_rd) begin
            nc = nc - q.cnt[k];
         end
         d.cnt[k] = nc;
      end

      // Reversal flag and sign bit move together
      for (int p = 0; p < 3; p++) begin
         if (rev_set[p]) begin
            set[STAT_REV_LSB + p] = 1'b1;
            d.psign[p] = step[q.sel ? p + 3 : p].dn;
         end
      end

      // Register writes
      if (bus_req.wr) begin
         case (bus_req.addr)
            ADDR_THR_LOW: begin
               d.thr_lo = bus_req.wdata[THR_HALF_W-1:0];
               d.lo_wr  = 1'b1;
            end
            ADDR_THR_HIGH: begin
               d.thr_hi = bus_req.wdata[THR_HALF_W-1:0];
               d.hi_wr  = 1'b1;
            end
            ADDR_STATUS:   clr = bus_req.wdata[STAT_W-1:0];
            ADDR_MASK:     d.mask = bus_req.wdata[STAT_W-1:0];
            ADDR_ACC_CFG: begin
               d.sel    = bus_req.wdata[CFG_SEL_BIT];
               d.wiring_config_sel = bus_req.wdata[CFG_WIRING_CONFIG_SEL_LSB +: 2];
            end
            ADDR_LINE_CFG: d.clr_rd = bus_req.wdata[LCC_CLR_BIT];
            default: ;
         endcase
      end

      // Threshold moves only as a whole pair, never half-updated
      if (d.lo_wr && d.hi_wr) begin
         d.thr   = {d.thr_hi, d.thr_lo};
         d.lo_wr = 1'b0;
         d.hi_wr = 1'b0;
      end

      // Sticky status: an event wins over a clear in the same cycle
      d.status = (q.status & ~clr) | set;
      d.irq_n  = ~|(d.status & d.mask);

      // Read data, one cycle after the strobe; unmapped reads as zero
      d.rdata = '0;
      if (bus_req.rd) begin
         if (e_hit) begin
            d.rdata = q.cnt[e_idx];
         end else begin
            case (bus_req.addr)
               ADDR_THR_LOW:    d.rdata = {8'h00, q.thr[THR_HALF_W-1:0]};
               ADDR_THR_HIGH:   d.rdata = {8'h00, q.thr[THR_W-1:THR_HALF_W]};
               ADDR_STATUS:     d.rdata = 32'(q.status);
               ADDR_MASK:       d.rdata = 32'(q.mask);
               ADDR_PHASE_SIGN: d.rdata = 32'(q.psign);
               ADDR_ACC_CFG:    d.rdata = 32'({q.sel, q.wiring_config_sel}) << CFG_WIRING_CONFIG_SEL_LSB;
               ADDR_LINE_CFG:   d.rdata = 32'(q.clr_rd) << LCC_CLR_BIT;
               default:         d.rdata = '0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q        <= '0;
         q.thr    <= THR_RESET;
         q.mask   <= MASK_RESET;
         q.wiring_config_sel <= WIRING_CONFIG_SEL_RESET;
         q.irq_n  <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state flops
   assign rdata           = q.rdata;
   assign interrupt_out_n = q.irq_n;
   assign energy_pulse    = q.pulse;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_read_e0_clr;
      bus_req.rd && e_hit && (e_idx == 3'h0) && q.clr_rd && !sample_en;
   endsequence

   sequence s_thr_low_only;
      bus_req.wr && (bus_req.addr == ADDR_THR_LOW) && !q.hi_wr;
   endsequence

   sample_tick_a: assert property (sample_en |=> q.div == '0 ##1 !sample_en)
      else $error("sample divider out of step");

   pulse_up_a: assert property (sample_en && step[0].up |=> q.pulse[0]
      && q.acc[0] == $past(step[0].acc))
      else $error("threshold crossing gave no pulse or wrong residue");

   reversal_a: assert property (rev_set[0] |=> q.status[STAT_REV_LSB]
      && q.psign[0] == $past(step[q.sel ? 3 : 0].dn))
      else $error("reversal not flagged with sign");

   sign_flag_a: assert property ((q.psign != $past(q.psign))
      |-> $past(|rev_set[2:0]))
      else $error("sign bits moved without reversal");

   irq_level_a: assert property ((|(q.status & q.mask)) == !interrupt_out_n)
      else $error("interrupt level disagrees with flags");

   clear_w1c_a: assert property (bus_req.wr && bus_req.addr == ADDR_STATUS
      && bus_req.wdata[STAT_REV_LSB] && !rev_set[0] |=> !q.status[STAT_REV_LSB])
      else $error("write one did not clear reversal flag");

   count_wrap_a: assert property (sample_en && step[0].up && q.cnt[0] == 32'h7fffffff
      && !(bus_req.rd && e_hit) |=> q.cnt[0] == 32'h80000000)
      else $error("energy count did not wrap");

   half_full_a: assert property ((q.cnt[1][HF_BIT] != $past(q.cnt[1][HF_BIT]))
      |-> q.status[STAT_TOT_HF])
      else $error("half-full flag missed");

   read_clear_a: assert property (s_read_e0_clr |=> q.cnt[0] == '0
      && rdata == $past(q.cnt[0]))
      else $error("clear-on-read failed");

   // High half may follow with no gap, so the pending mark is checked only one cycle on
   thr_pair_a: assert property (s_thr_low_only |=> $stable(q.thr) && q.lo_wr)
      else $error("threshold moved on a half write");

endmodule : aea_top

// ==== tb_active_energy_accumulator.sv ====
/*
 * Self-checking bench for the active energy accumulator: runs every wiring
 * code with random steady powers, then checks energy counts, signs, flags,
 * interrupt and clear-on-read against a reference worked out here.
 * Assumes the first sample tick lands 1250 clocks after reset release.
 */
`timescale 1ns/100ps

module tb_active_energy_accumulator;
   import aea_pkg::*;

   localparam int THR   = 5000;
   localparam int TICKS = 6;

   logic         clk;
   logic         rst;
   aea_bus_req_t bus_req;
   logic [31:0]  rdata;
   aea_ac_pwr_t  tot_pwr_ac;
   aea_ac_pwr_t  fund_pwr_ac;
   aea_volt_t    tot_volt;
   aea_volt_t    fund_volt;
   logic         interrupt_out_n;
   logic [5:0]   energy_pulse;
   int           mismatches;
   int           samples_checked;
   int           cyc;
   int           start;
   int           chan_p [6];
   int           pulse_seen [6];

   aea_top u_dut (
      .clk             (clk),
      .rst             (rst),
      .bus_req         (bus_req),
      .rdata           (rdata),
      .tot_pwr_ac      (tot_pwr_ac),
      .fund_pwr_ac     (fund_pwr_ac),
      .tot_volt        (tot_volt),
      .fund_volt       (fund_volt),
      .interrupt_out_n (interrupt_out_n),
      .energy_pulse    (energy_pulse)
   );

   aea_host_model u_host (
      .clk     (clk),
      .bus_req (bus_req),
      .rdata   (rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Clock, cycle count and hang guard
   always #50 clk = ~clk;

   always @(posedge clk) begin
      cyc++;
      // Pulses per chain since the last reset, for the pulse count check
      for (int k = 0; k < 6; k++) begin
         pulse_seen[k] = rst ? 0 : pulse_seen[k] + int'(energy_pulse[k]);
      end
      if (cyc > 40000) begin
         mismatches++;
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reference helpers
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic give_verdict();
      if (mismatches == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   function automatic int rnd(input int lim);
      return int'($urandom_range(2 * lim)) - lim;
   endfunction : rnd

   // Phase B power from the wiring code, truncated to 32 bits
   function automatic int pwr_b(input aea_volt_t v, input logic [1:0] code);
      int vs;
      case (code)
         WIRE_NORMAL:   vs = int'($signed(v.vb));
         WIRE_B_ZERO:   vs = 0;
         WIRE_B_NEG_AC: vs = -int'($signed(v.va)) - int'($signed(v.vc));
         default:       vs = -int'($signed(v.va));
      endcase
      return vs * int'($signed(v.ib));
   endfunction : pwr_b

   // First stage against THR, second stage as a signed pulse count
   task automatic sim(input int p, output int cnt, output logic neg);
      longint acc;
      acc = 0;
      cnt = 0;
      neg = 1'b0;
      for (int i = 0; i < TICKS; i++) begin
         acc += p;
         if (acc >= THR) begin
            acc -= THR;
            cnt++;
         end else if (acc <= -THR) begin
            acc += THR;
            cnt--;
            neg = 1'b1;
         end
      end
   endtask : sim

   // Reset with fresh random powers; corner values sit one below threshold
   task automatic do_reset(input logic [1:0] code);
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      tot_pwr_ac  <= '{a: rnd(THR - 1), c: -(THR - 1)};
      fund_pwr_ac <= '{a: rnd(THR - 1), c: THR - 1};
      tot_volt    <= '{va: 16'(rnd(50)), vb: 16'(rnd(50)), vc: 16'(rnd(50)), ib: 16'(rnd(40))};
      fund_volt   <= '{va: 16'(rnd(50)), vb: 16'(rnd(50)), vc: 16'(rnd(50)), ib: 16'(rnd(40))};
      rst         <= 1'b0;
      start = cyc;
      @(negedge clk);
      chan_p[0] = tot_pwr_ac.a;
      chan_p[1] = pwr_b(tot_volt, code);
      chan_p[2] = tot_pwr_ac.c;
      chan_p[3] = fund_pwr_ac.a;
      chan_p[4] = pwr_b(fund_volt, code);
      chan_p[5] = fund_pwr_ac.c;
   endtask : do_reset

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence: one pass per wiring code
   initial begin
      logic [31:0] rd_v;
      logic [8:0]  msk;
      logic [2:0]  sgn;
      logic [1:0]  hf;
      logic        sel;
      logic        neg;
      int          cnt;
      clk = 1'b0;
      rst = 1'b1;
      tot_pwr_ac = '0;
      fund_pwr_ac = '0;
      tot_volt = '0;
      fund_volt = '0;
      mismatches = 0;
      samples_checked = 0;
      cyc = 0;
      void'($urandom(32'hfe3b));
      for (int code = 0; code < 4; code++) begin
         do_reset(2'(code));
         if (code == 0) begin
            for (int a = 0; a <= 8'h40; a += 4) begin
               u_host.read_reg(8'(a), rd_v);
               check(rd_v, 32'h0);
            end
            check({31'h0, interrupt_out_n}, 32'h1);
            u_host.write_reg(ADDR_THR_LOW, 32'hffffffff);
            u_host.write_reg(ADDR_THR_HIGH, 32'ha5123456);
            u_host.read_reg(ADDR_THR_LOW, rd_v);
            check(rd_v, 32'h00ffffff);
            u_host.read_reg(ADDR_THR_HIGH, rd_v);
            check(rd_v, 32'h00123456);
            u_host.write_reg(ADDR_ENERGY0, 32'hffffffff);
         end
         u_host.write_thr(48'(THR));
         sel = 1'($urandom);
         msk = 9'($urandom) & 9'h1c3;
         u_host.write_reg(ADDR_MASK, {23'h0, msk});
         u_host.write_reg(ADDR_ACC_CFG, {25'h0, sel, 2'(code), 4'h0});
         u_host.write_reg(ADDR_LINE_CFG, {25'h0, code[0], 6'h0});
         u_host.read_reg(ADDR_ACC_CFG, rd_v);
         check(rd_v, {25'h0, sel, 2'(code), 4'h0});
         u_host.read_reg(ADDR_LINE_CFG, rd_v);
         check(rd_v, {25'h0, code[0], 6'h0});
         while (cyc < start + 1250 * TICKS + 600) @(posedge clk);
         // Energy counts per chain, and zero after a read when clearing is on
         hf = 2'b00;
         for (int i = 0; i < 6; i++) begin
            sim(chan_p[i], cnt, neg);
            if ((i / 3) == int'(sel))
               sgn[i % 3] = neg;
            // The first step below zero flips bit 30, so a negative count is half-full
            if (cnt < 0)
               hf[i / 3] = 1'b1;
            check(32'(pulse_seen[i]), 32'((cnt < 0) ? -cnt : cnt));
            u_host.read_reg(ADDR_ENERGY0 + 8'(4 * i), rd_v);
            check(rd_v, 32'(cnt));
            if (code[0]) begin
               u_host.read_reg(ADDR_ENERGY0 + 8'(4 * i), rd_v);
               check(rd_v, 32'h0);
            end
         end
         // Sign bits, reversal flags and the interrupt they raise
         u_host.read_reg(ADDR_PHASE_SIGN, rd_v);
         check(rd_v, {29'h0, sgn});
         u_host.read_reg(ADDR_STATUS, rd_v);
         check(rd_v, {23'h0, sgn, 4'h0, hf});
         check({31'h0, interrupt_out_n}, {31'h0, ~|(msk & {sgn, 4'h0, hf})});
         u_host.write_reg(ADDR_STATUS, 32'h0);
         u_host.read_reg(ADDR_STATUS, rd_v);
         check(rd_v, {23'h0, sgn, 4'h0, hf});
         u_host.write_reg(ADDR_STATUS, 32'h000001ff);
         u_host.read_reg(ADDR_STATUS, rd_v);
         check(rd_v, 32'h0);
         check({31'h0, interrupt_out_n}, 32'h1);
      end
      give_verdict();
   end

endmodule : tb_active_energy_accumulator
